// ---- hdl/qpio_top.sv ----
// Four 8-bit I/O ports with output latches, pin drivers and alternate function routing.
`timescale 1ns/1ps
`include "qpio_map.svh"
module qpio_top
  import qpio_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_en,
  input wire qpio_port_sel_t i_wr_sel,
  input wire logic [7:0] i_wr_data,
  input wire logic [7:0] i_open_drain_port_bit,
  output logic [7:0] o_open_drain_port_bit,
  output logic [7:0] o_open_drain_port_bit_oe,
  input wire logic [7:0] i_pulse_port_bit,
  output logic [7:0] o_pulse_port_bit,
  output logic [7:0] o_pulse_port_bit_oe,
  output logic [7:0] o_pulse_port_bit_pu,
  input wire logic [7:0] i_pulse_channel_out,
  input wire logic [7:0] i_pulse_channel_en,
  input wire logic [7:0] i_analog_port_bit,
  output logic [7:0] o_analog_port_bit,
  output logic [7:0] o_analog_port_bit_oe,
  output logic [7:0] o_analog_port_bit_pu,
  output logic [3:0] o_analog_sel,
  input wire logic [7:0] i_alt_func_port_bit,
  output logic [7:0] o_alt_func_port_bit,
  output logic [7:0] o_alt_func_port_bit_oe,
  output logic [7:0] o_alt_func_port_bit_pu,
  input wire logic i_serial_tx,
  input wire logic [3:0] i_analog_enable,
  output logic [7:0] o_open_drain_pins,
  output logic [7:0] o_pulse_pins,
  output logic [7:0] o_analog_pins,
  output logic [7:0] o_alt_pins,
  output logic [7:0] o_open_drain_latch,
  output logic [7:0] o_pulse_latch,
  output logic [7:0] o_analog_latch,
  output logic [7:0] o_alt_latch,
  output logic o_ext_irq_zero_in,
  output logic o_ext_irq_one_in,
  output logic o_timer_gate_zero,
  output logic o_timer_gate_one,
  output logic o_count_zero_in,
  output logic o_count_one_in,
  output logic o_serial_rx
);
  // Raw pin levels and their sampler stages, one byte per port.
  qpio_byte_t pin_in [4];
  qpio_byte_t sync_a [4];
  qpio_byte_t sync_b [4];
  qpio_byte_t sync_c [4];
  qpio_byte_t pin_val [4];
  qpio_byte_t next_pin_val [4];

  // Output latches as software last wrote them.
  qpio_byte_t latch [4];
  qpio_byte_t next_latch [4];

  // Pad controls of the open-drain port.
  qpio_byte_t od_drive;
  qpio_byte_t od_oe;
  qpio_byte_t next_od_drive;
  qpio_byte_t next_od_oe;

  // Pad controls of the pulse port.
  qpio_byte_t pulse_drive;
  qpio_byte_t pulse_oe;
  qpio_byte_t pulse_pu;
  qpio_byte_t next_pulse_drive;
  qpio_byte_t next_pulse_oe;
  qpio_byte_t next_pulse_pu;

  // Pad controls of the analog port and its analog select.
  qpio_byte_t ana_drive;
  qpio_byte_t ana_oe;
  qpio_byte_t ana_pu;
  qpio_byte_t next_ana_drive;
  qpio_byte_t next_ana_oe;
  qpio_byte_t next_ana_pu;
  logic [3:0] ana_sel;
  logic [3:0] next_ana_sel;

  // Pad controls of the alternate function port.
  qpio_byte_t alt_drive;
  qpio_byte_t alt_oe;
  qpio_byte_t alt_pu;
  qpio_byte_t next_alt_drive;
  qpio_byte_t next_alt_oe;
  qpio_byte_t next_alt_pu;

  assign pin_in[0] = i_open_drain_port_bit;
  assign pin_in[1] = i_pulse_port_bit;
  assign pin_in[2] = i_analog_port_bit;
  assign pin_in[3] = i_alt_func_port_bit;

  // Pins are asynchronous: three stages, and a change is taken once stages two and three
  // agree. The agreement costs a cycle of latency but keeps a slow or noisy edge from
  // reaching the interrupt and counter inputs as two transitions.
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      if (sync_b[p] == sync_c[p]) begin
        next_pin_val[p] = sync_c[p];
      end else begin
        next_pin_val[p] = pin_val[p];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int p = 0; p < 4; p++) begin
        sync_a[p] <= `QPIO_SYNC_RESET;
        sync_b[p] <= `QPIO_SYNC_RESET;
        sync_c[p] <= `QPIO_SYNC_RESET;
        pin_val[p] <= `QPIO_SYNC_RESET;
      end
    end else begin
      for (int p = 0; p < 4; p++) begin
        sync_a[p] <= pin_in[p];
        sync_b[p] <= sync_a[p];
        sync_c[p] <= sync_b[p];
        pin_val[p] <= next_pin_val[p];
      end
    end
  end

  // Several ports may be written in one cycle; each takes the same data byte.
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      if (i_wr_en && i_wr_sel[p]) begin
        next_latch[p] = i_wr_data;
      end else begin
        next_latch[p] = latch[p];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int p = 0; p < 4; p++) begin
        latch[p] <= `QPIO_LATCH_RESET;
      end
    end else begin
      for (int p = 0; p < 4; p++) begin
        latch[p] <= next_latch[p];
      end
    end
  end

  // Open drain: the pad only ever pulls low, and a latch one floats the pin.
  always_comb begin
    next_od_drive = 8'h00;
    next_od_oe = ~latch[0];
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      od_drive <= 8'h00;
      od_oe <= 8'h00;
    end else begin
      od_drive <= next_od_drive;
      od_oe <= next_od_oe;
    end
  end

  // An enabled pulse channel overrides its latch bit, so software need not park the
  // latch at one while the channel runs; a disabled channel gives the pin back.
  always_comb begin
    next_pulse_drive = (latch[1] & ~i_pulse_channel_en)
      | (i_pulse_channel_out & i_pulse_channel_en);
    next_pulse_oe = ~next_pulse_drive;
    next_pulse_pu = 8'hFF;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_drive <= 8'h00;
      pulse_oe <= 8'h00;
      pulse_pu <= 8'h00;
    end else begin
      pulse_drive <= next_pulse_drive;
      pulse_oe <= next_pulse_oe;
      pulse_pu <= next_pulse_pu;
    end
  end

  // The low nibble never drives, whatever its latch holds; the high nibble is a
  // pulled-up line driven low for a zero latch.
  always_comb begin
    next_ana_drive = {latch[2][7:4], 4'h0};
    next_ana_oe = {~latch[2][7:4], 4'h0};
    next_ana_pu = 8'hF0;
    next_ana_sel = i_analog_enable;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ana_drive <= 8'h00;
      ana_oe <= 8'h00;
      ana_pu <= 8'h00;
      ana_sel <= 4'h0;
    end else begin
      ana_drive <= next_ana_drive;
      ana_oe <= next_ana_oe;
      ana_pu <= next_ana_pu;
      ana_sel <= next_ana_sel;
    end
  end

  // Transmit is ANDed with its latch bit: a zero latch holds the line low and blocks
  // the serial output, which is why software keeps that latch at one.
  always_comb begin
    next_alt_drive = latch[3];
    next_alt_drive[`QPIO_BIT_TX] = latch[3][`QPIO_BIT_TX] & i_serial_tx;
    next_alt_oe = ~next_alt_drive;
    next_alt_pu = 8'hFF;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alt_drive <= 8'h00;
      alt_oe <= 8'h00;
      alt_pu <= 8'h00;
    end else begin
      alt_drive <= next_alt_drive;
      alt_oe <= next_alt_oe;
      alt_pu <= next_alt_pu;
    end
  end

  assign o_open_drain_port_bit = od_drive;
  assign o_open_drain_port_bit_oe = od_oe;
  assign o_pulse_port_bit = pulse_drive;
  assign o_pulse_port_bit_oe = pulse_oe;
  assign o_pulse_port_bit_pu = pulse_pu;
  assign o_analog_port_bit = ana_drive;
  assign o_analog_port_bit_oe = ana_oe;
  assign o_analog_port_bit_pu = ana_pu;
  assign o_analog_sel = ana_sel;
  assign o_alt_func_port_bit = alt_drive;
  assign o_alt_func_port_bit_oe = alt_oe;
  assign o_alt_func_port_bit_pu = alt_pu;

  assign o_open_drain_pins = pin_val[0];
  assign o_pulse_pins = pin_val[1];
  assign o_analog_pins = pin_val[2];
  assign o_alt_pins = pin_val[3];

  assign o_open_drain_latch = latch[0];
  assign o_pulse_latch = latch[1];
  assign o_analog_latch = latch[2];
  assign o_alt_latch = latch[3];

  // Alternate inputs read the filtered pin whatever the latch holds, so a zero latch
  // makes them see the device's own low drive rather than the board.
  assign o_ext_irq_zero_in = pin_val[3][`QPIO_BIT_IRQ_ZERO];
  assign o_timer_gate_zero = pin_val[3][`QPIO_BIT_IRQ_ZERO];
  assign o_ext_irq_one_in = pin_val[3][`QPIO_BIT_IRQ_ONE];
  assign o_timer_gate_one = pin_val[3][`QPIO_BIT_IRQ_ONE];
  assign o_count_zero_in = pin_val[3][`QPIO_BIT_COUNT_ZERO];
  assign o_count_one_in = pin_val[3][`QPIO_BIT_COUNT_ONE];
  assign o_serial_rx = pin_val[3][`QPIO_BIT_RX];
endmodule

// ---- hdl/qpio_map.svh ----
// Constants for the quad port I/O block: reset values, field positions and pin counts.
// Functional notes
// - First port: eight open-drain lines, no pull-up.
// - First-port latch one releases pin to float.
// - Second port pulled up; latch one allows input.
// - Pulse channel i drives second-port pin i.
// - Third port low nibble: digital or analog inputs.
// - Third port high nibble: pulled-up bidirectional lines.
// - Fourth port pulled up; latch one allows input.
// - Bits 2,3 feed interrupts and timer gates.
// - Bits 4,5 feed counter zero and one.
// - Bit 6 serial receive, bit 7 transmit.
`ifndef QPIO_MAP_SVH
`define QPIO_MAP_SVH
`define QPIO_LATCH_RESET 8'hFF
`define QPIO_WIDTH 8
`define QPIO_SYNC_RESET 8'hFF
`define QPIO_BIT_IRQ_ZERO 2
`define QPIO_BIT_IRQ_ONE 3
`define QPIO_BIT_COUNT_ZERO 4
`define QPIO_BIT_COUNT_ONE 5
`define QPIO_BIT_RX 6
`define QPIO_BIT_TX 7
`define QPIO_ANALOG_LO 0
`define QPIO_ANALOG_HI 3
`endif

// ---- hdl/qpio_pkg.sv ----
// Types shared by the quad port I/O block.
package qpio_pkg;
  typedef logic [7:0] qpio_byte_t;
  typedef enum logic [3:0] {
    QPIO_PORT_OPEN = 4'h1,
    QPIO_PORT_PULSE = 4'h2,
    QPIO_PORT_ANALOG = 4'h4,
    QPIO_PORT_ALT = 4'h8
  } qpio_port_sel_t;
endpackage

// ---- test/qpio_asserts.sv ----
// Port assertions for the quad port I/O block.
`timescale 1ns/1ps
module qpio_asserts
  import qpio_pkg::*;
(
  input wire logic i_ref_clk, i_rst_n, i_wr_en, o_serial_rx, o_count_one_in,
  input wire logic o_count_zero_in, o_ext_irq_one_in, o_ext_irq_zero_in,
  input wire qpio_port_sel_t i_wr_sel,
  input wire logic [7:0] i_wr_data, i_pulse_channel_en, i_alt_func_port_bit, o_alt_pins,
  input wire logic [7:0] o_open_drain_port_bit, o_open_drain_port_bit_oe, o_open_drain_latch,
  input wire logic [7:0] o_pulse_latch, o_pulse_port_bit_oe, o_analog_port_bit_oe,
  input wire logic [7:0] i_pulse_channel_out
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // Pins must stay put long enough to clear the synchroniser and its agreement stage.
  sequence pins_quiet; $stable(i_alt_func_port_bit)[*8]; endsequence
  sequence pulse_wr; i_wr_en && i_wr_sel[1] && !i_pulse_channel_en ##1 !i_pulse_channel_en;
  endsequence
  AST_OD_LOW: assert property (o_open_drain_port_bit == 8'h00) else $error("od high");
  AST_OD_OE: assert property (i_wr_en && i_wr_sel[0] |=>
    o_open_drain_latch == $past(i_wr_data) ##1 o_open_drain_port_bit_oe == ~$past(i_wr_data, 2))
    else $error("od oe");
  AST_PUL_LATCH: assert property (i_wr_en && i_wr_sel[1] |=>
    o_pulse_latch == $past(i_wr_data)) else $error("pulse latch");
  AST_PUL_OE: assert property (pulse_wr |=>
    o_pulse_port_bit_oe == ~$past(i_wr_data, 2)) else $error("pulse oe");
  AST_AN_IN: assert property (o_analog_port_bit_oe[3:0] == 4'h0) else $error("an oe");
  AST_PUL_PWM: assert property (i_pulse_channel_en == 8'hFF |=>
    o_pulse_port_bit_oe == ~$past(i_pulse_channel_out)) else $error("pulse pwm");
  AST_RST: assert property ($rose(i_rst_n) |->
    (o_open_drain_latch & o_pulse_latch) == 8'hFF) else $error("reset latch");
  AST_PINS: assert property (pins_quiet |-> o_alt_pins == i_alt_func_port_bit)
    else $error("alt pins");
  AST_ALT_IN: assert property (pins_quiet |->
    {o_serial_rx, o_count_one_in, o_count_zero_in, o_ext_irq_one_in, o_ext_irq_zero_in}
    == i_alt_func_port_bit[6:2]) else $error("alt inputs");
endmodule

// ---- test/qpio_board.sv ----
// Board model that settles eight port lines from device drive, pull-ups and board drive.
`timescale 1ns/1ps
module qpio_board (
  input wire logic [7:0] i_val, i_oe, i_pu, i_ext, i_ext_en,
  output logic [7:0] o_pin
);
  // A line nobody drives or pulls shows the inverse of the last drive, never a kept level.
  assign o_pin = (i_oe & i_val) | (~i_oe & i_ext_en & i_ext)
    | (~i_oe & ~i_ext_en & (i_pu | ~i_val));
endmodule

// ---- test/qpio_top_tb.sv ----
// Self-checking bench for the quad port I/O block.
`timescale 1ns/1ps
module qpio_top_tb;
  import qpio_pkg::*;
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_wr_en = 1'b0, i_serial_tx = 1'b1;
  qpio_port_sel_t i_wr_sel = QPIO_PORT_OPEN;
  logic [7:0] i_wr_data = 8'h00, i_pulse_channel_out = 8'h00, i_pulse_channel_en = 8'h00;
  logic [7:0] i_open_drain_port_bit = 8'hFF, i_pulse_port_bit = 8'hFF, i_analog_port_bit = 8'hFF;
  logic [7:0] ext = 8'h00, i_alt_func_port_bit;
  logic [3:0] i_analog_enable = 4'h0, o_analog_sel;
  logic [7:0] o_open_drain_port_bit, o_open_drain_port_bit_oe, o_pulse_port_bit, o_pulse_pins;
  logic [7:0] o_pulse_port_bit_oe, o_pulse_port_bit_pu, o_analog_port_bit, o_analog_port_bit_oe;
  logic [7:0] o_analog_port_bit_pu, o_alt_func_port_bit, o_alt_func_port_bit_oe, o_alt_pins;
  logic [7:0] o_alt_func_port_bit_pu, o_open_drain_pins, o_analog_pins, o_open_drain_latch;
  logic [7:0] o_pulse_latch, o_analog_latch, o_alt_latch;
  logic o_ext_irq_zero_in, o_ext_irq_one_in, o_timer_gate_zero, o_timer_gate_one;
  logic o_count_zero_in, o_count_one_in, o_serial_rx;
  int n_errors = 0, compares = 0;
  qpio_top dut_u (.*);
  qpio_board board_u (.i_val(o_alt_func_port_bit), .i_oe(o_alt_func_port_bit_oe),
    .i_pu(o_alt_func_port_bit_pu), .i_ext(ext), .i_ext_en(8'hFF), .o_pin(i_alt_func_port_bit));
  task automatic chk(string name, logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wr(qpio_port_sel_t sel, logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr_en <= 1'b1;
    i_wr_sel <= sel;
    i_wr_data <= d;
    @(posedge i_ref_clk);
    i_wr_en <= 1'b0;
  endtask
  task automatic stop_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    tick(2);
    chk("latches", o_open_drain_latch & o_pulse_latch & o_analog_latch & o_alt_latch, 8'hFF);
    chk("od oe", o_open_drain_port_bit_oe, 8'h00);
    $display("reset test done");
    wr(QPIO_PORT_OPEN, 8'h5A);
    tick(1);
    chk("od oe", o_open_drain_port_bit_oe, 8'hA5);
    chk("od drive", o_open_drain_port_bit, 8'h00);
    wr(QPIO_PORT_PULSE, 8'h3C);
    tick(1);
    chk("pulse oe", o_pulse_port_bit_oe, 8'hC3);
    chk("pulse pu", o_pulse_port_bit_pu, 8'hFF);
    chk("pulse latch", o_pulse_latch, 8'h3C);
    @(posedge i_ref_clk);
    i_pulse_channel_en <= 8'hFF;
    i_pulse_channel_out <= 8'h96;
    i_analog_enable <= 4'h5;
    tick(3);
    chk("pwm oe", o_pulse_port_bit_oe, 8'h69);
    chk("pwm out", o_pulse_port_bit, 8'h96);
    wr(QPIO_PORT_ANALOG, 8'h00);
    tick(1);
    chk("an oe", o_analog_port_bit_oe, 8'hF0);
    chk("an sel", {4'h0, o_analog_sel}, 8'h05);
    chk("an drive", o_analog_port_bit, 8'h00);
    chk("an pu", o_analog_port_bit_pu, 8'hF0);
    chk("an latch", o_analog_latch, 8'h00);
    $display("port test done");
    ext <= 8'h54;
    i_open_drain_port_bit <= 8'h3C;
    i_pulse_port_bit <= 8'h0F;
    i_analog_port_bit <= 8'hA5;
    wr(QPIO_PORT_ALT, 8'hFF);
    tick(8);
    chk("alt pins", o_alt_pins, 8'h54);
    chk("alt in", {3'h0, o_serial_rx, o_count_one_in, o_count_zero_in, o_ext_irq_one_in,
      o_ext_irq_zero_in}, 8'h15);
    chk("gates", {6'h00, o_timer_gate_one, o_timer_gate_zero}, 8'h01);
    chk("od pins", o_open_drain_pins, 8'h3C);
    chk("pulse pins", o_pulse_pins, 8'h0F);
    chk("an pins", o_analog_pins, 8'hA5);
    chk("alt pu", o_alt_func_port_bit_pu, 8'hFF);
    chk("alt latch", o_alt_latch, 8'hFF);
    @(posedge i_ref_clk);
    i_serial_tx <= 1'b0;
    tick(3);
    chk("tx oe", {7'h00, o_alt_func_port_bit_oe[7]}, 8'h01);
    chk("tx drive", o_alt_func_port_bit, 8'h7F);
    $display("alt test done");
    stop_test();
  end
endmodule
bind qpio_top qpio_asserts chk_u (.*);
